// ### logic/cmw_pkg.sv
// constants, types and helpers of the can mode and window control block
//
// Contract
// - control bits 7:5 request normal 000, disable 001, loopback 010, listen 011
// - any mode request with bit 7 set means configuration mode
// - control bit 4 set aborts all pending transmissions in every buffer
// - control bits 3:1 choose the buffer mapped into the access window
// - window 101 rx1, 100 tx0, 011 tx1, 010 tx2, others rx0
// - status bits 7:5 show the current mode, 101 to 111 reserved
// - status bits 3:1 hold a prioritised code of the interrupt source
// - codes: 111 wake, 110 rx0, 101 rx1, 100 tx0, 011 tx1, 010 tx2
// - interrupt code and window select share one encoding
// - control bit 0 and status bits 4 and 0 read as zero

package cmw_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] CMW_OFS_CTRL   = 8'h00;
	localparam logic [7:0] CMW_OFS_STATUS = 8'h04;
	localparam logic [7:0] CMW_OFS_IRQST  = 8'h08;
	localparam logic [7:0] CMW_OFS_IRQMSK = 8'h0C;

	// ************************************************************
	// field layout and reset values
	// ************************************************************
	localparam int         CMW_MODE_HI   = 7;
	localparam int         CMW_MODE_LO   = 5;
	localparam int         CMW_ABORT_BIT = 4;
	localparam int         CMW_WIN_HI    = 3;
	localparam int         CMW_WIN_LO    = 1;
	localparam logic [7:0] CMW_CTRL_RST  = 8'h80;
	localparam logic [7:0] CMW_CTRL_WMSK = 8'hFE;
	localparam int         CMW_NUM_SRC   = 7;
	localparam logic [6:0] CMW_IRQ_RST   = 7'h00;
	localparam logic [1:0] CMW_RESP_OK   = 2'h0;
	localparam logic [1:0] CMW_RESP_ERR  = 2'h2;

	// interrupt source bit positions in the sticky flags
	localparam int CMW_SRC_ERR  = 0;
	localparam int CMW_SRC_TX2  = 1;
	localparam int CMW_SRC_TX1  = 2;
	localparam int CMW_SRC_TX0  = 3;
	localparam int CMW_SRC_RX1  = 4;
	localparam int CMW_SRC_RX0  = 5;
	localparam int CMW_SRC_WAKE = 6;

	// ************************************************************
	// encodings
	// ************************************************************
	typedef enum logic [2:0] {
		CMW_NORMAL   = 3'h0,
		CMW_DISABLE  = 3'h1,
		CMW_LOOPBACK = 3'h2,
		CMW_LISTEN   = 3'h3,
		CMW_CONFIG   = 3'h4
	} cmw_mode_type;

	// shared by interrupt code and window select
	typedef enum logic [2:0] {
		CMW_C_NONE = 3'h0,
		CMW_C_ERR  = 3'h1,
		CMW_C_TX2  = 3'h2,
		CMW_C_TX1  = 3'h3,
		CMW_C_TX0  = 3'h4,
		CMW_C_RX1  = 3'h5,
		CMW_C_RX0  = 3'h6,
		CMW_C_WAKE = 3'h7
	} cmw_code_type;

	// one-hot buffer select: rx0, rx1, tx0, tx1, tx2
	localparam logic [4:0] CMW_SEL_RX0 = 5'h01;
	localparam logic [4:0] CMW_SEL_RX1 = 5'h02;
	localparam logic [4:0] CMW_SEL_TX0 = 5'h04;
	localparam logic [4:0] CMW_SEL_TX1 = 5'h08;
	localparam logic [4:0] CMW_SEL_TX2 = 5'h10;

	// address is one of the four mapped words
	function automatic logic cmw_mapped(input logic [31:0] a);
		return a == 32'(CMW_OFS_CTRL) || a == 32'(CMW_OFS_STATUS) ||
			a == 32'(CMW_OFS_IRQST) || a == 32'(CMW_OFS_IRQMSK);
	endfunction

endpackage

// ### logic/cmw_reg_if.sv
// register access carrier between bus slave and register file
`timescale 1ns/1ps
`default_nettype none

interface cmw_reg_if #(parameter int ADDR_W = 8);
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0]       rd_data;

	modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input rd_data);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output rd_data);
endinterface

`default_nettype wire

// ### logic/cmw_axil_slave.sv
// axi4-lite slave front end
`timescale 1ns/1ps
`default_nettype none

module cmw_axil_slave #(
	parameter int ADDR_W = 8
) (
	// clock, enable, reset
	input  wire logic              aclk,
	input  wire logic              aclken,
	input  wire logic              aresetn,
	// write channels
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	// read channels
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	// register side
	cmw_reg_if.slave               rif
);
	import cmw_pkg::*;

	logic              aw_full_r;
	logic              w_full_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              do_wr;

	// write issues once both halves are held
	assign do_wr       = aw_full_r && w_full_r && !bvalid;
	assign rif.wr_en   = do_wr && aclken && cmw_mapped(32'(awaddr_r));
	assign rif.wr_addr = awaddr_r;
	assign rif.wr_data = wdata_r;
	assign rif.wr_strb = wstrb_r;
	assign rif.rd_addr = araddr;

	// write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
		end else if (aclken) begin
			if (awvalid && awready) begin
				aw_full_r <= 1'b1;
				awaddr_r  <= awaddr;
				awready   <= 1'b0;
			end else if (!aw_full_r && !bvalid) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				w_full_r <= 1'b1;
				wdata_r  <= wdata;
				wstrb_r  <= wstrb;
				wready   <= 1'b0;
			end else if (!w_full_r && !bvalid) begin
				wready <= 1'b1;
			end
			if (do_wr) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= CMW_RESP_OK;
		end else if (aclken) begin
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp  <= cmw_mapped(32'(awaddr_r)) ? CMW_RESP_OK
					: CMW_RESP_ERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read path, data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= CMW_RESP_OK;
		end else if (aclken) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rif.rd_data;
				rresp   <= cmw_mapped(32'(araddr)) ? CMW_RESP_OK
					: CMW_RESP_ERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end else if (!rvalid) begin
				arready <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ### logic/cmw_prio_enc.sv
// prioritised interrupt source encoder
`timescale 1ns/1ps
`default_nettype none

module cmw_prio_enc (
	// pending, unmasked sources
	input  wire logic [6:0] pend,
	// code of the winning source
	output cmw_pkg::cmw_code_type code
);
	import cmw_pkg::*;

	// wake highest, error lowest
	always_comb begin
		if (pend[CMW_SRC_WAKE])
			code = CMW_C_WAKE;
		else if (pend[CMW_SRC_RX0])
			code = CMW_C_RX0;
		else if (pend[CMW_SRC_RX1])
			code = CMW_C_RX1;
		else if (pend[CMW_SRC_TX0])
			code = CMW_C_TX0;
		else if (pend[CMW_SRC_TX1])
			code = CMW_C_TX1;
		else if (pend[CMW_SRC_TX2])
			code = CMW_C_TX2;
		else if (pend[CMW_SRC_ERR])
			code = CMW_C_ERR;
		else
			code = CMW_C_NONE;
	end

endmodule

`default_nettype wire

// ### logic/cmw_top.sv
// can mode request, window select and status register block
`timescale 1ns/1ps
`default_nettype none

module cmw_top #(
	parameter int ADDR_W = 8
) (
	// clock, enable, reset
	input  wire logic              aclk,
	input  wire logic              aclken,
	input  wire logic              aresetn,
	// axi4-lite write channels
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [ADDR_W-1:0] s_awaddr,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	output logic [1:0]             s_bresp,
	// axi4-lite read channels
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	input  wire logic [ADDR_W-1:0] s_araddr,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	// protocol engine status and events
	input  wire logic              engine_idle,
	input  wire logic              evt_wake,
	input  wire logic              evt_receive_buffer_0,
	input  wire logic              evt_receive_buffer_1,
	input  wire logic              evt_transmit_buffer_0,
	input  wire logic              evt_transmit_buffer_1,
	input  wire logic              evt_transmit_buffer_2,
	input  wire logic              evt_error,
	// controls to the protocol engine and buffers
	output cmw_pkg::cmw_mode_type  mode_request,
	output cmw_pkg::cmw_mode_type  mode_status,
	output logic                   abort_all_tx,
	output logic [4:0]             window_buf_sel,
	// interrupt
	output logic                   irq
);
	import cmw_pkg::*;

	// ************************************************************
	// parameter check
	// ************************************************************
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
		$error("cmw_top: ADDR_W must lie between 8 and 32");
	end

	// window decode, shared with the interrupt code encoding
	function automatic logic [4:0] win_decode(input logic [2:0] w);
		case (w)
			CMW_C_RX1: win_decode = CMW_SEL_RX1;
			CMW_C_TX0: win_decode = CMW_SEL_TX0;
			CMW_C_TX1: win_decode = CMW_SEL_TX1;
			CMW_C_TX2: win_decode = CMW_SEL_TX2;
			default:   win_decode = CMW_SEL_RX0;
		endcase
	endfunction

	// requested mode from the control field
	function automatic cmw_mode_type req_decode(input logic [2:0] r);
		if (r[2])
			req_decode = CMW_CONFIG;
		else
			req_decode = cmw_mode_type'(r);
	endfunction

	// ************************************************************
	// bus slave
	// ************************************************************
	cmw_reg_if #(.ADDR_W(ADDR_W)) rif ();

	cmw_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
		.aclk    (aclk),
		.aclken  (aclken),
		.aresetn (aresetn),
		.awvalid (s_awvalid),
		.awready (s_awready),
		.awaddr  (s_awaddr),
		.wvalid  (s_wvalid),
		.wready  (s_wready),
		.wdata   (s_wdata),
		.wstrb   (s_wstrb),
		.bvalid  (s_bvalid),
		.bready  (s_bready),
		.bresp   (s_bresp),
		.arvalid (s_arvalid),
		.arready (s_arready),
		.araddr  (s_araddr),
		.rvalid  (s_rvalid),
		.rready  (s_rready),
		.rdata   (s_rdata),
		.rresp   (s_rresp),
		.rif     (rif.slave)
	);

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0]   ctrl_r;
	logic [6:0]   irq_flags_r;
	logic [6:0]   irq_flags_nxt;
	logic [6:0]   irq_mask_r;
	logic [6:0]   evt_vec;
	logic [6:0]   pend;
	cmw_code_type prio_code;
	cmw_code_type icode_r;
	cmw_mode_type mode_nxt;
	logic         wr_ctrl;
	logic         wr_irqst;
	logic         wr_irqmsk;
	logic [7:0]   status_word;

	assign wr_ctrl   = rif.wr_en && rif.wr_strb[0] &&
		32'(rif.wr_addr) == 32'(CMW_OFS_CTRL);
	assign wr_irqst  = rif.wr_en && rif.wr_strb[0] &&
		32'(rif.wr_addr) == 32'(CMW_OFS_IRQST);
	assign wr_irqmsk = rif.wr_en && rif.wr_strb[0] &&
		32'(rif.wr_addr) == 32'(CMW_OFS_IRQMSK);

	// control register, bit 0 never stored
	// control reset value
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_r <= CMW_CTRL_RST;
		else if (aclken && wr_ctrl)
			ctrl_r <= rif.wr_data[7:0] & CMW_CTRL_WMSK;
	end

	// decoded controls to the engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_request   <= CMW_CONFIG;
			abort_all_tx   <= 1'b0;
			window_buf_sel <= CMW_SEL_RX0;
		end else if (aclken) begin
			mode_request   <= req_decode(ctrl_r[CMW_MODE_HI:CMW_MODE_LO]);
			abort_all_tx   <= ctrl_r[CMW_ABORT_BIT];
			window_buf_sel <= win_decode(ctrl_r[CMW_WIN_HI:CMW_WIN_LO]);
		end
	end

	// ************************************************************
	// operating mode tracking
	// ************************************************************
	// follow only when the engine has settled
	always_comb begin
		mode_nxt = mode_status;
		case (mode_status)
			CMW_NORMAL, CMW_DISABLE, CMW_LOOPBACK, CMW_LISTEN,
			CMW_CONFIG: begin
				if (engine_idle && mode_request != mode_status)
					mode_nxt = mode_request;
			end
			default: mode_nxt = CMW_CONFIG;
		endcase
	end

	// current mode held for the status register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			mode_status <= CMW_CONFIG;
		else if (aclken)
			mode_status <= mode_nxt;
	end

	// ************************************************************
	// interrupt flags, mask and code
	// ************************************************************
	assign evt_vec = {evt_wake, evt_receive_buffer_0, evt_receive_buffer_1, evt_transmit_buffer_0,
		evt_transmit_buffer_1, evt_transmit_buffer_2, evt_error};
	assign pend    = irq_flags_r & irq_mask_r;

	// write one to clear, a new event wins over the clear
	always_comb begin
		irq_flags_nxt = irq_flags_r;
		if (wr_irqst)
			irq_flags_nxt = irq_flags_nxt & ~rif.wr_data[6:0];
		irq_flags_nxt = irq_flags_nxt | evt_vec;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_flags_r <= CMW_IRQ_RST;
		else if (aclken)
			irq_flags_r <= irq_flags_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_mask_r <= CMW_IRQ_RST;
		else if (aclken && wr_irqmsk)
			irq_mask_r <= rif.wr_data[6:0];
	end

	cmw_prio_enc u_prio (
		.pend (pend),
		.code (prio_code)
	);

	// code of the highest pending source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			icode_r <= CMW_C_NONE;
			irq     <= 1'b0;
		end else if (aclken) begin
			icode_r <= prio_code;
			irq     <= |pend;
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	// status bits 4 and 0 zero, code in window layout
	assign status_word = {mode_status, 1'b0, icode_r, 1'b0};

	always_comb begin
		case (32'(rif.rd_addr))
			32'(CMW_OFS_CTRL):   rif.rd_data = {24'h0, ctrl_r};
			32'(CMW_OFS_STATUS): rif.rd_data = {24'h0, status_word};
			32'(CMW_OFS_IRQST):  rif.rd_data = {25'h0, irq_flags_r};
			32'(CMW_OFS_IRQMSK): rif.rd_data = {25'h0, irq_mask_r};
			default:             rif.rd_data = 32'h0;
		endcase
	end

	// ************************************************************
	// assertions
	// ************************************************************
	property p_reset_val;
		@(posedge aclk) !aresetn |=> ctrl_r == CMW_CTRL_RST &&
			mode_status == CMW_CONFIG;
	endproperty
	a_reset_val: assert property (p_reset_val)
		else $error("control or mode wrong after reset");

	property p_req_cfg;
		@(posedge aclk) disable iff (!aresetn)
		aclken && ctrl_r[CMW_MODE_HI] |=> mode_request == CMW_CONFIG;
	endproperty
	a_req_cfg: assert property (p_req_cfg)
		else $error("msb set did not request configuration");

	property p_req_low;
		@(posedge aclk) disable iff (!aresetn)
		aclken && !ctrl_r[CMW_MODE_HI] |=>
			mode_request == $past(ctrl_r[CMW_MODE_HI:CMW_MODE_LO]);
	endproperty
	a_req_low: assert property (p_req_low)
		else $error("mode request not decoded");

	property p_abort;
		@(posedge aclk) disable iff (!aresetn)
		aclken |=> abort_all_tx == $past(ctrl_r[CMW_ABORT_BIT]);
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort output does not follow control");

	property p_window;
		@(posedge aclk) disable iff (!aresetn)
		aclken && ctrl_r[CMW_WIN_HI:CMW_WIN_LO] == icode_r &&
			icode_r == CMW_C_RX1 |=> window_buf_sel == CMW_SEL_RX1;
	endproperty
	a_window: assert property (p_window)
		else $error("copied code did not map its buffer");

	property p_win_map;
		@(posedge aclk) disable iff (!aresetn)
		aclken |=> window_buf_sel ==
			win_decode($past(ctrl_r[CMW_WIN_HI:CMW_WIN_LO]));
	endproperty
	a_win_map: assert property (p_win_map)
		else $error("window select decoded wrongly");

	property p_zero_bits;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_r[0] == 1'b0 && status_word[4] == 1'b0 &&
			status_word[0] == 1'b0;
	endproperty
	a_zero_bits: assert property (p_zero_bits)
		else $error("unimplemented bit not zero");

	property p_mode_hold;
		@(posedge aclk) disable iff (!aresetn)
		aclken && !engine_idle |=> $stable(mode_status);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed while engine busy");

	property p_mode_move;
		@(posedge aclk) disable iff (!aresetn)
		aclken && engine_idle |=> mode_status == $past(mode_request);
	endproperty
	a_mode_move: assert property (p_mode_move)
		else $error("mode status did not follow request");

	property p_wake_code;
		@(posedge aclk) disable iff (!aresetn)
		aclken && pend[CMW_SRC_WAKE] |=> icode_r == CMW_C_WAKE && irq;
	endproperty
	a_wake_code: assert property (p_wake_code)
		else $error("wake source not top priority");

	property p_no_code;
		@(posedge aclk) disable iff (!aresetn)
		aclken && pend == 7'h00 |=> icode_r == CMW_C_NONE && !irq;
	endproperty
	a_no_code: assert property (p_no_code)
		else $error("code or irq set with nothing pending");

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		aclken && evt_error && wr_irqst |=> irq_flags_r[CMW_SRC_ERR];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost against clear");

	c_to_normal: cover property (@(posedge aclk) disable iff (!aresetn)
		mode_status == CMW_CONFIG ##1 mode_status == CMW_NORMAL);
	c_abort: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(abort_all_tx));
	c_wake: cover property (@(posedge aclk) disable iff (!aresetn)
		icode_r == CMW_C_WAKE);
	c_win_tx2: cover property (@(posedge aclk) disable iff (!aresetn)
		window_buf_sel == CMW_SEL_TX2);

endmodule

`default_nettype wire

// ### tb/cmw_tb.sv
// self-checking bench of the can mode and window control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import cmw_pkg::*;

	// ************************************************************
	// stimulus, design outputs and the instance
	// ************************************************************
	typedef struct {
		logic [7:0] ctrl;
		logic [2:0] mode;
		logic [4:0] sel;
	} cmw_row_type;

	logic         aclk        = 1'b0;
	logic         aclken      = 1'b1;
	logic         aresetn     = 1'b0;
	logic         s_awvalid   = 1'b0;
	logic [7:0]   s_awaddr    = 8'h00;
	logic         s_wvalid    = 1'b0;
	logic [31:0]  s_wdata     = 32'h0;
	logic [3:0]   s_wstrb     = 4'hF;
	logic         s_bready    = 1'b0;
	logic         s_arvalid   = 1'b0;
	logic [7:0]   s_araddr    = 8'h00;
	logic         s_rready    = 1'b0;
	logic         engine_idle = 1'b1;
	logic [6:0]   evt         = 7'h00;
	logic         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
	logic         abort_all_tx;
	logic [1:0]   s_bresp, s_rresp, resp;
	logic [31:0]  s_rdata, rd, saved;
	logic [4:0]   window_buf_sel;
	cmw_mode_type mode_request, mode_status;
	int           n_mismatch  = 0;
	int           checks_done = 0;
	cmw_row_type  rows [8] = '{'{8'h00, 3'h0, 5'h01}, '{8'h2F, 3'h1, 5'h01},
		'{8'h54, 3'h2, 5'h10}, '{8'h66, 3'h3, 5'h08}, '{8'hA8, 3'h4, 5'h04},
		'{8'hCA, 3'h4, 5'h02}, '{8'hFD, 3'h4, 5'h01}, '{8'h12, 3'h0, 5'h01}};

	// 25 mhz clock
	always #20 aclk = ~aclk;

	cmw_top cmw_top_inst (.aclk(aclk), .aclken(aclken), .aresetn(aresetn),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
		.s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .engine_idle(engine_idle),
		.evt_wake(evt[6]), .evt_receive_buffer_0(evt[5]), .evt_receive_buffer_1(evt[4]),
		.evt_transmit_buffer_0(evt[3]), .evt_transmit_buffer_1(evt[2]), .evt_transmit_buffer_2(evt[1]),
		.evt_error(evt[0]), .mode_request(mode_request),
		.mode_status(mode_status), .abort_all_tx(abort_all_tx),
		.window_buf_sel(window_buf_sel), .irq(irq));

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_awvalid && s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready === 1'b1) s_wvalid <= 1'b0;
			if (s_bvalid === 1'b1) begin
				resp = s_bresp;
				s_bready <= 1'b0;
				break;
			end
		end
		if (i == 64) begin
			chk(32'h0, 32'h1);
			end_sim;
		end
	endtask

	// read: address held until taken, rready held until rvalid
	task automatic axi_rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_arvalid && s_arready === 1'b1) s_arvalid <= 1'b0;
			if (s_rvalid === 1'b1) begin
				rd   = s_rdata;
				resp = s_rresp;
				s_rready <= 1'b0;
				break;
			end
		end
		if (i == 64) begin
			chk(32'h0, 32'h1);
			end_sim;
		end
	endtask

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d);
		chk(32'(resp), 32'(CMW_RESP_OK));
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a);
		chk(32'(resp), 32'(CMW_RESP_OK));
		chk(rd, exp);
	endtask

	// one-hot buffer expected for a window value
	function automatic logic [4:0] sel_of(input logic [2:0] c);
		case (c)
			3'h5: return 5'h02;
			3'h4: return 5'h04;
			3'h3: return 5'h08;
			3'h2: return 5'h10;
			default: return 5'h01;
		endcase
	endfunction

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(2);
		rd_chk(CMW_OFS_CTRL, 32'h80);
		rd_chk(CMW_OFS_STATUS, 32'h80);
		chk(32'(window_buf_sel), 32'h01);
		// table of mode, abort and window writes
		for (int i = 0; i < 8; i++) begin
			wr_ok(CMW_OFS_CTRL, 32'(rows[i].ctrl));
			cyc(3);
			chk(32'(mode_request), 32'(rows[i].mode));
			chk(32'(abort_all_tx), 32'(rows[i].ctrl[4]));
			chk(32'(window_buf_sel), 32'(rows[i].sel));
			rd_chk(CMW_OFS_CTRL, 32'(rows[i].ctrl & 8'hFE));
			rd_chk(CMW_OFS_STATUS, 32'({rows[i].mode, 5'h00}));
		end
		// mode status waits for the engine, disable asked before sleep
		engine_idle <= 1'b0;
		wr_ok(CMW_OFS_CTRL, 32'h20);
		cyc(4);
		chk(32'(mode_request), 32'h1);
		rd_chk(CMW_OFS_STATUS, 32'h00);
		engine_idle <= 1'b1;
		cyc(3);
		chk(32'(mode_status), 32'h1);
		wr_ok(CMW_OFS_CTRL, 32'h00);
		// masked source gives no code
		evt <= 7'h01;
		cyc(1);
		evt <= 7'h00;
		cyc(3);
		chk(32'(irq), 32'h0);
		rd_chk(CMW_OFS_STATUS, 32'h00);
		rd_chk(CMW_OFS_IRQST, 32'h01);
		wr_ok(CMW_OFS_IRQMSK, 32'h7F);
		cyc(3);
		rd_chk(CMW_OFS_STATUS, 32'h02);
		// every source at once, cleared highest first
		evt <= 7'h7F;
		cyc(1);
		evt <= 7'h00;
		cyc(3);
		for (int c = 7; c > 0; c--) begin
			rd_chk(CMW_OFS_STATUS, 32'(c) << 1);
			chk(32'(irq), 32'h1);
			// handler saves control before moving the window
			axi_rd(CMW_OFS_CTRL);
			saved = rd;
			wr_ok(CMW_OFS_CTRL, 32'(c) << 1);
			cyc(3);
			chk(32'(window_buf_sel), 32'(sel_of(3'(c))));
			wr_ok(CMW_OFS_IRQST, 32'h1 << (c - 1));
			wr_ok(CMW_OFS_CTRL, saved);
			cyc(3);
		end
		chk(32'(irq), 32'h0);
		rd_chk(CMW_OFS_STATUS, 32'h00);
		// unmapped place and read-only status
		axi_rd(8'h10);
		chk(32'(resp), 32'(CMW_RESP_ERR));
		chk(rd, 32'h0);
		axi_wr(8'h10, 32'hFF);
		chk(32'(resp), 32'(CMW_RESP_ERR));
		wr_ok(CMW_OFS_STATUS, 32'hFF);
		rd_chk(CMW_OFS_STATUS, 32'h00);
		// clock enable low freezes the flags against an event
		aclken <= 1'b0;
		evt    <= 7'h01;
		cyc(3);
		evt    <= 7'h00;
		aclken <= 1'b1;
		cyc(2);
		chk(32'(irq), 32'h0);
		rd_chk(CMW_OFS_IRQST, 32'h00);
		// second reset in mid-run
		wr_ok(CMW_OFS_CTRL, 32'h54);
		cyc(3);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(2);
		chk(32'(mode_status), 32'h4);
		chk(32'(abort_all_tx), 32'h0);
		rd_chk(CMW_OFS_CTRL, 32'h80);
		rd_chk(CMW_OFS_IRQMSK, 32'h00);
		end_sim;
	end

endmodule

`default_nettype wire
